// file: logic/sadc_host.sv
// Host end: drives select/read/start/power-down in one of four modes.
// Assumes a request pulse from user logic and the device on the link.
`timescale 1ns/1ps
module sadc_host
	import sadc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	sadc_link_if.host link,
	input wire sadc_mode_t mode,
	input wire logic request,
	input wire logic powerDown,
	output logic ready,
	output logic [SADC_DATA_W-1:0] resultData,
	output logic resultValid
);
	typedef enum logic [1:0] {SADC_H_IDLE, SADC_H_PULSE, SADC_H_WAIT, SADC_H_READ} sadc_hstate_t;
	typedef struct packed {
		logic [1:0] busySync;
		sadc_hstate_t phase;
		logic [SADC_CNT_W-1:0] count;
		logic [SADC_CNT_W-1:0] gap;
		logic startN;
		logic readN;
		logic [SADC_DATA_W-1:0] data;
		logic valid;
	} sadc_host_t;
	sadc_host_t cur;
	sadc_host_t next_cur;
	// ==========================================
	// Sequencer
	always_comb begin
		next_cur = cur;
		next_cur.busySync = {cur.busySync[0], link.busyN};
		next_cur.valid = 1'b0;
		// Spacing covers wake-up and throughput period
		// Shutdown keeps at least the wake-up span, so no start lands before wake
		if (powerDown) begin
			if (cur.gap < SADC_CNT_W'(SADC_WAKE_CYC)) begin
				next_cur.gap = SADC_CNT_W'(SADC_WAKE_CYC);
			end
		end else if (cur.gap != SADC_CNT_RST) begin
			next_cur.gap = cur.gap - 8'h01;
		end
		unique case (cur.phase)
			SADC_H_IDLE: begin
				if (request && cur.gap == SADC_CNT_RST && !powerDown) begin
					next_cur.phase = SADC_H_PULSE;
					next_cur.count = SADC_CNT_RST;
					next_cur.startN = 1'b0;
					next_cur.readN = (mode == SADC_MODE_SLOWMEM || mode == SADC_MODE_ROM)
						? 1'b0 : (mode != SADC_MODE_ALWAYS);
					next_cur.gap = SADC_CNT_W'(SADC_PERIOD_CYC);
				end
			end
			SADC_H_PULSE: begin
				// Hold start until device has surely seen it
				if (cur.count == 8'h04) begin
					next_cur.phase = SADC_H_WAIT;
					if (mode != SADC_MODE_SLOWMEM) begin
						next_cur.startN = 1'b1;
						if (mode != SADC_MODE_ALWAYS) next_cur.readN = 1'b1;
					end
				end else begin
					next_cur.count = cur.count + 8'h01;
				end
			end
			SADC_H_WAIT: begin
				// Wait state while busy low; bus quiet in shared and ROM modes only, read stays low in the others
				if (cur.busySync[1] && cur.count > 8'h08) begin
					next_cur.phase = SADC_H_READ;
					next_cur.readN = (mode == SADC_MODE_SHARED || mode == SADC_MODE_ALWAYS)
						? 1'b0 : cur.readN;
					next_cur.count = SADC_CNT_RST;
				end else begin
					next_cur.count = cur.count + 8'h01;
				end
			end
			SADC_H_READ: begin
				// Let read settle across the device synchroniser
				if (cur.count == 8'h04) begin
					next_cur.data = link.dataBus;
					next_cur.valid = 1'b1;
					next_cur.startN = 1'b1;
					next_cur.readN = (mode == SADC_MODE_ALWAYS) ? 1'b0 : 1'b1;
					next_cur.phase = SADC_H_IDLE;
				end else begin
					next_cur.count = cur.count + 8'h01;
				end
			end
		endcase
	end
	// ==========================================
	// State register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cur <= '{busySync: 2'h3, phase: SADC_H_IDLE, count: SADC_CNT_RST,
				gap: 8'h30, startN: 1'b1, readN: 1'b1, data: SADC_RESULT_RST,
				valid: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end
	// ==========================================
	// Pins and user side
	assign link.chipSelectN = 1'b0;
	assign link.conversionStartN = cur.startN;
	assign link.readN = cur.readN;
	assign link.power_down_n = !powerDown;
	assign ready = (cur.phase == SADC_H_IDLE) && (cur.gap == SADC_CNT_RST) && !powerDown;
	assign resultData = cur.data;
	assign resultValid = cur.valid;
endmodule : sadc_host

// file: logic/sadc_pkg.sv
// Shared constants for the sampling converter control and its host end.
// Assumes a single 100 MHz core clock on both ends.
package sadc_pkg;
	// ==========================================
	// Widths and clock
	localparam int SADC_DATA_W = 12;
	localparam int SADC_CLK_PERIOD_NS = 10;
	// ==========================================
	// Times as printed, then cycle counts
	localparam int SADC_CONV_TIME_NS = 1400;
	localparam int SADC_ACQ_TIME_NS = 160;
	localparam int SADC_WAKE_TIME_NS = 350;
	localparam int SADC_THROUGHPUT_KSPS = 600;
	localparam int SADC_CONV_CYC = SADC_CONV_TIME_NS / SADC_CLK_PERIOD_NS;
	localparam int SADC_ACQ_CYC = (SADC_ACQ_TIME_NS + SADC_CLK_PERIOD_NS - 1) / SADC_CLK_PERIOD_NS;
	localparam int SADC_WAKE_CYC = (SADC_WAKE_TIME_NS + SADC_CLK_PERIOD_NS - 1)
		/ SADC_CLK_PERIOD_NS;
	localparam int SADC_PERIOD_CYC = (1000000 + SADC_THROUGHPUT_KSPS * SADC_CLK_PERIOD_NS - 1)
		/ (SADC_THROUGHPUT_KSPS * SADC_CLK_PERIOD_NS);
	localparam int SADC_CNT_W = 8;
	// ==========================================
	// Reset values
	localparam logic [SADC_DATA_W-1:0] SADC_RESULT_RST = 12'h000;
	localparam logic [SADC_CNT_W-1:0] SADC_CNT_RST = 8'h00;
	// Host operating modes
	typedef enum logic [1:0] {
		SADC_MODE_ALWAYS,
		SADC_MODE_SHARED,
		SADC_MODE_SLOWMEM,
		SADC_MODE_ROM
	} sadc_mode_t;
endpackage : sadc_pkg

// file: logic/sadc_link_if.sv
// Bus wires between converter and host; data bus resolved from enables.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface sadc_link_if;
	import sadc_pkg::*;
	logic chipSelectN;
	logic readN;
	logic conversionStartN;
	logic power_down_n;
	logic busyN;
	logic [SADC_DATA_W-1:0] dataOut;
	logic dataOe;
	logic [SADC_DATA_W-1:0] dataBus;
	// Undriven bus floats to zero here; no z in design code
	assign dataBus = dataOe ? dataOut : '0;
	modport device (input chipSelectN, input readN, input conversionStartN,
		input power_down_n, output busyN, output dataOut, output dataOe);
	modport host (output chipSelectN, output readN, output conversionStartN,
		output power_down_n, input busyN, input dataBus, input dataOe);
endinterface : sadc_link_if

// file: logic/sadc_device.sv
// Converter control end: start logic, busy, result latch, output enable.
// Assumes pins arrive asynchronously; the analog SAR is a sample input.
`timescale 1ns/1ps
module sadc_device
	import sadc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	sadc_link_if.device link,
	input wire logic [SADC_DATA_W-1:0] sampleCode,
	input wire logic bipolarMode,
	output logic sampleHold,
	output logic conversionDone
);
	typedef enum logic [1:0] {SADC_IDLE, SADC_CONV, SADC_ACQ} sadc_dstate_t;
	typedef struct packed {
		logic [1:0] csSync;
		logic [1:0] rdSync;
		logic [1:0] startSync;
		logic [1:0] pdSync;
		logic startPrev;
		sadc_dstate_t phase;
		logic [SADC_CNT_W-1:0] count;
		logic [SADC_CNT_W-1:0] wakeCount;
		logic [SADC_DATA_W-1:0] result;
		logic done;
	} sadc_dev_t;
	sadc_dev_t cur;
	sadc_dev_t next_cur;
	logic startFall;
	logic awake;
	// ==========================================
	// Format: bipolar is two's complement, offset code flips the top bit
	function automatic logic [SADC_DATA_W-1:0] sadcFormat(input logic [SADC_DATA_W-1:0] c,
		input logic bip);
		sadcFormat = bip ? {~c[SADC_DATA_W-1], c[SADC_DATA_W-2:0]} : c;
	endfunction : sadcFormat
	// ==========================================
	// Next state
	always_comb begin
		next_cur = cur;
		next_cur.csSync = {cur.csSync[0], link.chipSelectN};
		next_cur.rdSync = {cur.rdSync[0], link.readN};
		next_cur.startSync = {cur.startSync[0], link.conversionStartN};
		next_cur.pdSync = {cur.pdSync[0], link.power_down_n};
		next_cur.startPrev = cur.startSync[1];
		next_cur.done = 1'b0;
		// Wake counter restarts on each shutdown
		if (!cur.pdSync[1]) begin
			next_cur.wakeCount = SADC_CNT_RST;
		end else if (cur.wakeCount < SADC_CNT_W'(SADC_WAKE_CYC)) begin
			next_cur.wakeCount = cur.wakeCount + 8'h01;
		end
		// Start taken on the falling edge only, so a start held low gives one conversion
		startFall = cur.startPrev && !cur.startSync[1];
		awake = cur.pdSync[1] && (cur.wakeCount >= SADC_CNT_W'(SADC_WAKE_CYC));
		unique case (cur.phase)
			SADC_IDLE: begin
				// Starts seen while blocked are dropped, never queued
				if (startFall && !cur.csSync[1] && awake) begin
					next_cur.phase = SADC_CONV;
					next_cur.count = SADC_CNT_RST;
				end
			end
			SADC_CONV: begin
				// Starts ignored until the end of conversion
				if (cur.count == SADC_CNT_W'(SADC_CONV_CYC - 1)) begin
					next_cur.result = sadcFormat(sampleCode, bipolarMode);
					next_cur.done = 1'b1;
					next_cur.phase = SADC_ACQ;
					next_cur.count = SADC_CNT_RST;
				end else begin
					next_cur.count = cur.count + 8'h01;
				end
			end
			SADC_ACQ: begin
				// Track time before the next start may be honoured
				if (cur.count == SADC_CNT_W'(SADC_ACQ_CYC - 1)) begin
					next_cur.phase = SADC_IDLE;
				end else begin
					next_cur.count = cur.count + 8'h01;
				end
			end
		endcase
	end
	// ==========================================
	// State register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cur <= '{csSync: 2'h3, rdSync: 2'h3, startSync: 2'h3, pdSync: 2'h0,
				startPrev: 1'b1, phase: SADC_IDLE, count: SADC_CNT_RST,
				wakeCount: SADC_CNT_RST, result: SADC_RESULT_RST, done: 1'b0};
		end else begin
			cur <= next_cur;
		end
	end
	// ==========================================
	// Outputs; result latch holds the previous code during conversion
	assign link.busyN = (cur.phase != SADC_CONV);
	assign link.dataOut = cur.result;
	assign link.dataOe = !cur.csSync[1] && !cur.rdSync[1];
	assign sampleHold = (cur.phase == SADC_CONV);
	assign conversionDone = cur.done;
endmodule : sadc_device

// file: test/sadc_monitor.sv
// Checker for the converter link; sees only the shared wires.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module sadc_monitor
	import sadc_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic chipSelectN,
	input wire logic readN,
	input wire logic conversionStartN,
	input wire logic power_down_n,
	input wire logic busyN,
	input wire logic [SADC_DATA_W-1:0] dataOut,
	input wire logic dataOe
);
	localparam logic [7:0] CONV_N = 8'(SADC_CONV_CYC);
	localparam logic [7:0] GAP_N = 8'(SADC_CONV_CYC + SADC_ACQ_CYC);
	localparam logic [7:0] WAKE_N = 8'(SADC_WAKE_CYC);
	logic [7:0] lowCnt;
	logic [7:0] gapCnt;
	logic [7:0] wakeCnt;
	// ==========================================
	// Span counters; gap and wake counters saturate so long idle spans never wrap
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lowCnt <= 8'h00;
			gapCnt <= 8'hFF;
			wakeCnt <= 8'h00;
		end else begin
			lowCnt <= busyN ? 8'h00 : lowCnt + 8'h01;
			gapCnt <= $fell(busyN) ? 8'h01 : (gapCnt == 8'hFF) ? gapCnt : gapCnt + 8'h01;
			wakeCnt <= !power_down_n ? 8'h00 : (wakeCnt == 8'hFF) ? wakeCnt : wakeCnt + 8'h01;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_acq; busyN[*8] ##1 busyN[*8]; endsequence
	sequence s_shown; (!chipSelectN && !readN)[*4]; endsequence
	property p_busy_len; $rose(busyN) |-> lowCnt == CONV_N; endproperty
	property p_start_cause; $fell(busyN) |-> !$past(conversionStartN, 3)
		&& !$past(chipSelectN, 3) && $past(power_down_n, 3); endproperty
	property p_no_restart; $fell(busyN) |-> gapCnt >= GAP_N; endproperty
	property p_wake; $fell(busyN) |-> wakeCnt >= WAKE_N; endproperty
	property p_acq; $rose(busyN) |-> s_acq; endproperty
	property p_result_time; $changed(dataOut) |-> $rose(busyN); endproperty
	property p_oe_on; s_shown |-> dataOe; endproperty
	property p_oe_off; readN[*4] |-> !dataOe; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy low span wrong");
	a_start_cause: assert property (p_start_cause) else $error("start cause");
	a_no_restart: assert property (p_no_restart) else $error("restart early");
	a_wake: assert property (p_wake) else $error("start before wake");
	a_acq: assert property (p_acq) else $error("acquisition cut");
	a_result_time: assert property (p_result_time) else $error("result moved");
	a_oe_on: assert property (p_oe_on) else $error("outputs not driven");
	a_oe_off: assert property (p_oe_off) else $error("outputs not floating");
endmodule : sadc_monitor

// file: test/sampling_adc_bus_control_tb_top.sv
// Bench top: host and converter ends joined on one link.
// Assumes package, interface and both ends compiled first.
`timescale 1ns/1ps
module sampling_adc_bus_control_tb_top
	import sadc_pkg::*;
();
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	sadc_mode_t mode = SADC_MODE_ALWAYS;
	logic request = 1'b0;
	logic powerDown = 1'b0;
	logic [11:0] sampleCode = 12'h000;
	logic bipolarMode = 1'b0;
	logic ready;
	logic [11:0] resultData;
	logic resultValid;
	logic sampleHold;
	logic conversionDone;
	logic lowSeen = 1'b0;
	int doneCount = 0;
	int doneMark = 0;
	logic [11:0] prevResult = 12'h000;
	logic [11:0] codes [8] = '{12'h000, 12'h001, 12'hFFE, 12'hFFF,
		12'h7FF, 12'h800, 12'hFFF, 12'h000};
	// Expected codes: straight binary, then two's complement for the bipolar half
	logic [11:0] wants [8] = '{12'h000, 12'h001, 12'hFFE, 12'hFFF,
		12'hFFF, 12'h000, 12'h7FF, 12'h800};
	int miscompares = 0;
	int checks = 0;
	sadc_link_if link();
	sadc_device i_sadc_device (.core_clk(core_clk), .reset(reset), .link(link.device),
		.sampleCode(sampleCode), .bipolarMode(bipolarMode), .sampleHold(sampleHold),
		.conversionDone(conversionDone));
	sadc_host i_sadc_host (.core_clk(core_clk), .reset(reset), .link(link.host),
		.mode(mode), .request(request), .powerDown(powerDown), .ready(ready),
		.resultData(resultData), .resultValid(resultValid));
	sadc_monitor i_sadc_monitor (.core_clk(core_clk), .reset(reset),
		.chipSelectN(link.chipSelectN), .readN(link.readN),
		.conversionStartN(link.conversionStartN), .power_down_n(link.power_down_n),
		.busyN(link.busyN), .dataOut(link.dataOut), .dataOe(link.dataOe));
	// ==========================================
	// Clock and helpers
	always #5 core_clk = ~core_clk;
	// Done pulse lasts one cycle; tally it away from the launching edge
	always @(negedge core_clk) begin
		if (conversionDone === 1'b1) doneCount++;
	end
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	// Inputs move 1 ns after the edge, clear of sampling
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	// Bounded wait: 0 ready, 1 busy, 2 result valid
	task automatic wait_on(input int sel, input logic level);
		for (int n = 0; n < 600; n++) begin
			if (((sel == 0) ? ready : (sel == 1) ? link.busyN : resultValid) === level) begin
				return;
			end
			tick();
		end
		miscompares++;
		$display("ERROR at %0t: wait %0d timed out", $time, sel);
	endtask : wait_on
	// One conversion in the given mode, bus checked mid-conversion
	task automatic convert(input sadc_mode_t m, input logic [11:0] code, input logic bip,
		input logic [11:0] want);
		int doneBase;
		mode = m;
		sampleCode = code;
		bipolarMode = bip;
		repeat (4) tick();
		wait_on(0, 1'b1);
		doneBase = doneCount;
		request = 1'b1;
		tick();
		request = 1'b0;
		wait_on(1, 1'b0);
		tick();
		check({11'h000, sampleHold}, 12'h001);
		if (m == SADC_MODE_SHARED) begin
			check({11'h000, link.dataOe}, 12'h000);
		end else begin
			check(link.dataBus, prevResult);
		end
		wait_on(2, 1'b1);
		check({11'h000, link.busyN}, 12'h001);
		check(12'(doneCount - doneBase), 12'h001);
		if (m == SADC_MODE_ALWAYS) begin
			check(link.dataBus, want);
		end
		if (m != SADC_MODE_ROM) begin
			check(resultData, want);
		end
		prevResult = want;
	endtask : convert
	// ==========================================
	// Tests
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		reset = 1'b0;
		for (int i = 0; i < 8; i++) begin
			convert(sadc_mode_t'(2'(i)), codes[i], i >= 4, wants[i]);
			$display("test sweep %0d done", i);
		end
		// Start pulse overlaps shutdown: must be refused and never replayed
		mode = SADC_MODE_SHARED;
		wait_on(0, 1'b1);
		doneMark = doneCount;
		request = 1'b1;
		tick();
		request = 1'b0;
		powerDown = 1'b1;
		lowSeen = 1'b0;
		repeat (60) begin
			tick();
			lowSeen |= !link.busyN;
		end
		check({11'h000, lowSeen}, 12'h000);
		check(resultData, prevResult);
		powerDown = 1'b0;
		repeat (60) begin
			tick();
			lowSeen |= !link.busyN;
		end
		check({11'h000, lowSeen}, 12'h000);
		check(12'(doneCount - doneMark), 12'h000);
		convert(SADC_MODE_SLOWMEM, 12'hA5C, 1'b0, 12'hA5C);
		$display("test shutdown done");
		end_of_test();
	end
	// Tests need under 4000 cycles; allow ten times that
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
endmodule : sampling_adc_bus_control_tb_top
